// [pkg/csrc_cfg.svh]
// Purpose: Constants of the counter serial read and clear port
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Offsets, field positions, counts and encodings only
`ifndef CSRC_CFG_SVH
`define CSRC_CFG_SVH

`define CSRC_NPORTS        5
`define CSRC_PRE_MIN       6'h20
`define CSRC_START_SECOND  1'h1
`define CSRC_OP_BITS       6'h02
`define CSRC_OP_READ       2'h2
`define CSRC_OP_CLEAR      2'h1
`define CSRC_RD_HDR_BITS   6'h08
`define CSRC_CLR_HDR_BITS  6'h0A
`define CSRC_TA_DRIVE      6'h01
`define CSRC_TA_LAST       6'h02
`define CSRC_DATA_BITS     6'h20
`define CSRC_TSEL_COUNTER  1'h1
`define CSRC_SCOPE_PORT    1'h1
`define CSRC_REG_TXOVF     7'h3B
`define CSRC_REG_COLOVF    7'h3C
`define CSRC_OVF_LAST_PORT 4
`define CSRC_OVF_LAST_POS  7
`define CSRC_OVF_HI_BASE   9
`define CSRC_IDX_BASE      7'h20
`define CSRC_IDX_STRIDE    7'h08
`define CSRC_KIND_TXPKT    0
`define CSRC_KIND_TXBYTE   1
`define CSRC_KIND_COL      2
`define CSRC_KIND_ERR      3

`endif

// [pkg/csrc_pkg.sv]
// Purpose: Types of the counter serial read and clear port
// Assumes: Constants come from csrc_cfg.svh
// Notes:   One-hot state codes written out
`default_nettype none
package csrc_pkg;

    typedef enum logic [5:0] {
        CSRC_ST_PRE   = 6'h01,
        CSRC_ST_START = 6'h02,
        CSRC_ST_OP    = 6'h04,
        CSRC_ST_HDR   = 6'h08,
        CSRC_ST_TA    = 6'h10,
        CSRC_ST_DATA  = 6'h20
    } csrc_state_type;

    typedef struct packed {
        logic       valid;
        logic       scope;
        logic [6:0] index;
    } csrc_clear_type;

    typedef struct packed {
        logic [4:0] tx_pkt;
        logic [4:0] tx_byte;
        logic [4:0] col;
        logic [4:0] err;
    } csrc_wrap_type;

endpackage : csrc_pkg
`default_nettype wire

// [rtl/csrc_port.sv]
// Purpose: Serial management port reading counters and EEPROM image, clearing counters
// Assumes: Link clock and data sampled by MCLK; counter store answers within a few MCLK
// Notes:   Overflow flag words at 0x3B and 0x3C are served from flags held here
// Summary of operation
// [RULE1] Controller sends at least 32 ones, then start pattern 01.
// [RULE2] Opcode 10 is read; no write path exists.
// [RULE3] Table select bit: 1 counters, 0 EEPROM image.
// [RULE4] A seven-bit address follows table select.
// [RULE5] After turnaround the device drives exactly 32 data bits.
// [RULE6] Counter words go out bit 31 first, bit 0 last.
// [RULE7] EEPROM: even N sends N+1 then N; odd N sends N then N-1.
// [RULE8] Controller keeps clocking at least one idle cycle between frames.
// [RULE9] Chip select held low; clock and data used like a management link.
// [RULE10] Opcode 01 is the counter clear command.
// [RULE11] Clear acts only when device address matches the strapped address.
// [RULE12] Scope bit 1 clears a whole port, 0 one counter.
// [RULE13] Scope bit is followed by the port number or counter index.
// [RULE14] Register 0x3B bits 0,2,4,6,7 hold transmit packet overflow flags.
// [RULE15] Register 0x3B bits 9,11,13,15,16 hold transmit byte overflow flags.
// [RULE16] Register 0x3C bits 0,2,4,6,7 hold collision overflow flags.
// [RULE17] Register 0x3C bits 9,11,13,15,16 hold error overflow flags.
// [RULE18] A flag sets on counter wrap and holds until its counter is cleared.
`timescale 1ns/100ps
`default_nettype none
`include "csrc_cfg.svh"

module csrc_port
    import csrc_pkg::*;
(
    input  wire logic           MCLK,        // System clock, 200 MHz
    input  wire logic           RST,         // Asynchronous reset, active high
    input  wire logic           SERIAL_PORT_CLOCK, // Link clock from controller
    input  wire logic           DATA_I,      // Serial data line, pin level
    output var  logic           DATA_O,      // Serial data line, driven value
    output var  logic           DATA_OE,     // Serial data line, drive enable
    input  wire logic [1:0]     STRAPPED_PHYSICAL_ADDRESS, // Strap pins
    output var  logic [6:0]     CNT_ADDR,    // Counter store read address
    input  wire logic [31:0]    CNT_DATA,    // Counter store read word
    output var  logic [6:0]     EE_HI_IDX,   // EEPROM entry sent first
    output var  logic [6:0]     EE_LO_IDX,   // EEPROM entry sent second
    input  wire logic [15:0]    EE_HI_WORD,  // Content of EE_HI_IDX
    input  wire logic [15:0]    EE_LO_WORD,  // Content of EE_LO_IDX
    input  wire csrc_wrap_type  WRAP,        // Counter wrap pulses per port
    output var  csrc_clear_type CLR_CMD      // Clear command pulse
);

    // Synchronisers; stage one is read only by stage two
    logic [2:0] sck_q, sck_d;
    logic [1:0] sdi_q, sdi_d;
    logic [1:0] strap_s1_q, strap_s1_d;
    logic [1:0] strap_q, strap_d;
    logic [1:0] strap_cap_q, strap_cap_d;
    logic [2:0] strap_done_q, strap_done_d; // Capture only once stage two holds the pins
    logic       rise;
    logic       fall;
    logic       bit_in;

    always_comb begin
        sck_d        = {sck_q[1:0], SERIAL_PORT_CLOCK};
        sdi_d        = {sdi_q[0], DATA_I};
        strap_s1_d   = STRAPPED_PHYSICAL_ADDRESS;
        strap_d      = strap_s1_q;
        strap_done_d = {strap_done_q[1:0], 1'b1};
        strap_cap_d  = strap_done_q[2] ? strap_cap_q : strap_q; // [RULE11]
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sck_q        <= 3'h0;
            sdi_q        <= 2'h0;
            strap_s1_q   <= 2'h0;
            strap_q      <= 2'h0;
            strap_cap_q  <= 2'h0;
            strap_done_q <= 3'h0;
        end else begin
            sck_q        <= sck_d;
            sdi_q        <= sdi_d;
            strap_s1_q   <= strap_s1_d;
            strap_q      <= strap_d;
            strap_cap_q  <= strap_cap_d;
            strap_done_q <= strap_done_d;
        end
    end

    assign rise   = sck_q[1] & ~sck_q[2];
    assign fall   = ~sck_q[1] & sck_q[2];
    assign bit_in = sdi_q[1];

    // Overflow flags, one per kind and port
    logic [3:0][4:0] flag_q, flag_d;
    logic [3:0][4:0] wrap_v;
    logic [31:0]     ovf_tx_w;
    logic [31:0]     ovf_cl_w;
    csrc_clear_type  clr_q, clr_d;

    assign wrap_v = {WRAP.err, WRAP.col, WRAP.tx_byte, WRAP.tx_pkt};

    for (genvar k = 0; k < 4; k++) begin : g_kind
        for (genvar p = 0; p < `CSRC_NPORTS; p++) begin : g_port
            logic hit;
            assign hit = clr_q.valid & ((clr_q.scope == `CSRC_SCOPE_PORT)
                       ? (clr_q.index == 7'(p))
                       : (clr_q.index == 7'(`CSRC_IDX_BASE + 7'(k) * `CSRC_IDX_STRIDE + 7'(p))));
            // Wrap wins over a clear in the same cycle
            assign flag_d[k][p] = wrap_v[k][p] | (flag_q[k][p] & ~hit); // [RULE18] [RULE12]
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flag_q <= '0; // [RULE14] [RULE16]
        end else begin
            flag_q <= flag_d;
        end
    end

    // Port 4 sits at bit 7, not 8, so the layout is not a plain stride
    function automatic int lo_pos(input int p);
        lo_pos = (p == `CSRC_OVF_LAST_PORT) ? `CSRC_OVF_LAST_POS : 2 * p;
    endfunction : lo_pos

    always_comb begin
        ovf_tx_w = 32'h0;
        ovf_cl_w = 32'h0;
        for (int p = 0; p < `CSRC_NPORTS; p++) begin
            ovf_tx_w[lo_pos(p)]                     = flag_q[`CSRC_KIND_TXPKT][p];  // [RULE14]
            ovf_tx_w[`CSRC_OVF_HI_BASE + lo_pos(p)] = flag_q[`CSRC_KIND_TXBYTE][p]; // [RULE15]
            ovf_cl_w[lo_pos(p)]                     = flag_q[`CSRC_KIND_COL][p];    // [RULE16]
            ovf_cl_w[`CSRC_OVF_HI_BASE + lo_pos(p)] = flag_q[`CSRC_KIND_ERR][p];    // [RULE17]
        end
    end

    // Frame engine: sample on link rising edges, drive after falling edges
    csrc_state_type state_q, state_d;
    logic [5:0]     cnt_q, cnt_d;
    logic [1:0]     op_q, op_d;
    logic [9:0]     hdr_q, hdr_d;
    logic [31:0]    sh_q, sh_d;
    logic           dout_q, dout_d;
    logic           doe_q, doe_d;
    logic [6:0]     caddr_q, caddr_d;
    logic [6:0]     ehi_q, ehi_d;
    logic [6:0]     elo_q, elo_d;
    logic [31:0]    word;

    always_comb begin
        if (hdr_q[7] == `CSRC_TSEL_COUNTER) begin // [RULE3]
            if (hdr_q[6:0] == `CSRC_REG_TXOVF) begin
                word = ovf_tx_w;
            end else if (hdr_q[6:0] == `CSRC_REG_COLOVF) begin
                word = ovf_cl_w;
            end else begin
                word = CNT_DATA;
            end
        end else begin
            word = {EE_HI_WORD, EE_LO_WORD}; // [RULE7]
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        op_d    = op_q;
        hdr_d   = hdr_q;
        sh_d    = sh_q;
        dout_d  = dout_q;
        doe_d   = doe_q;
        caddr_d = caddr_q;
        ehi_d   = ehi_q;
        elo_d   = elo_q;
        clr_d   = '0;
        case (state_q)
            CSRC_ST_PRE: begin
                if (rise) begin
                    if (bit_in) begin
                        cnt_d = (cnt_q == `CSRC_PRE_MIN) ? cnt_q : cnt_q + 6'h01; // [RULE1]
                    end else if (cnt_q == `CSRC_PRE_MIN) begin
                        state_d = CSRC_ST_START; // [RULE1]
                        cnt_d   = 6'h00;
                    end else begin
                        cnt_d = 6'h00;
                    end
                end
            end
            CSRC_ST_START: begin
                if (rise) begin
                    cnt_d   = 6'h00;
                    state_d = (bit_in == `CSRC_START_SECOND) ? CSRC_ST_OP : CSRC_ST_PRE; // [RULE1]
                end
            end
            CSRC_ST_OP: begin
                if (rise) begin
                    op_d  = {op_q[0], bit_in};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q + 6'h01 == `CSRC_OP_BITS) begin
                        cnt_d   = 6'h00;
                        // Anything but read or clear drops back to hunting
                        if ({op_q[0], bit_in} == `CSRC_OP_READ || {op_q[0], bit_in} == `CSRC_OP_CLEAR) begin
                            state_d = CSRC_ST_HDR; // [RULE2] [RULE10]
                        end else begin
                            state_d = CSRC_ST_PRE;
                        end
                    end
                end
            end
            CSRC_ST_HDR: begin
                if (rise) begin
                    hdr_d = {hdr_q[8:0], bit_in}; // [RULE4] [RULE13]
                    cnt_d = cnt_q + 6'h01;
                    if (op_q == `CSRC_OP_READ && cnt_q + 6'h01 == `CSRC_RD_HDR_BITS) begin
                        caddr_d = {hdr_q[5:0], bit_in};
                        ehi_d   = {hdr_q[5:0], 1'b1}; // [RULE7]
                        elo_d   = {hdr_q[5:0], 1'b0}; // [RULE7]
                        cnt_d   = 6'h00;
                        state_d = CSRC_ST_TA;
                    end else if (op_q == `CSRC_OP_CLEAR && cnt_q + 6'h01 == `CSRC_CLR_HDR_BITS) begin
                        cnt_d   = 6'h00;
                        state_d = CSRC_ST_PRE;
                        if (hdr_q[8:7] == strap_cap_q) begin // [RULE11]
                            clr_d.valid = 1'b1;
                            clr_d.scope = hdr_q[6]; // [RULE12]
                            clr_d.index = {hdr_q[5:0], bit_in};
                        end
                    end
                end
            end
            CSRC_ST_TA: begin
                if (rise) begin
                    cnt_d = cnt_q + 6'h01;
                end else if (fall && cnt_q == `CSRC_TA_DRIVE) begin
                    doe_d  = 1'b1;
                    dout_d = 1'b0;
                end else if (fall && cnt_q == `CSRC_TA_LAST) begin
                    sh_d    = {word[30:0], 1'b0};
                    dout_d  = word[31]; // [RULE6]
                    cnt_d   = 6'h01;
                    state_d = CSRC_ST_DATA;
                end
            end
            CSRC_ST_DATA: begin
                if (fall) begin
                    if (cnt_q == `CSRC_DATA_BITS) begin // [RULE5]
                        doe_d   = 1'b0;
                        dout_d  = 1'b0;
                        cnt_d   = 6'h00;
                        state_d = CSRC_ST_PRE;
                    end else begin
                        dout_d = sh_q[31]; // [RULE6]
                        sh_d   = {sh_q[30:0], 1'b0};
                        cnt_d  = cnt_q + 6'h01;
                    end
                end
            end
            default: begin
                state_d = CSRC_ST_PRE;
                cnt_d   = 6'h00;
                doe_d   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_q <= CSRC_ST_PRE;
            cnt_q   <= 6'h00;
            op_q    <= 2'h0;
            hdr_q   <= 10'h000;
            sh_q    <= 32'h0;
            dout_q  <= 1'b0;
            doe_q   <= 1'b0;
            caddr_q <= 7'h00;
            ehi_q   <= 7'h00;
            elo_q   <= 7'h00;
            clr_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            op_q    <= op_d;
            hdr_q   <= hdr_d;
            sh_q    <= sh_d;
            dout_q  <= dout_d;
            doe_q   <= doe_d;
            caddr_q <= caddr_d;
            ehi_q   <= ehi_d;
            elo_q   <= elo_d;
            clr_q   <= clr_d;
        end
    end

    assign DATA_O    = dout_q;
    assign DATA_OE   = doe_q;
    assign CNT_ADDR  = caddr_q;
    assign EE_HI_IDX = ehi_q;
    assign EE_LO_IDX = elo_q;
    assign CLR_CMD   = clr_q;

endmodule : csrc_port
`default_nettype wire

// [verif/csrc_properties.sv]
// Purpose: Assertions on the serial data pins, clear pulse and EEPROM entry pair
// Assumes: Bound to csrc_port; link clock much slower than MCLK
// Notes:   Link edges counted on the raw pin
`timescale 1ns/100ps
`default_nettype none
module csrc_props
    import csrc_pkg::*;
(
    input wire logic           MCLK,              // System clock
    input wire logic           RST,               // Async reset
    input wire logic           SERIAL_PORT_CLOCK, // Link clock
    input wire logic           DATA_O,            // Device data
    input wire logic           DATA_OE,           // Device drives
    input wire logic [6:0]     EE_HI_IDX,         // First entry
    input wire logic [6:0]     EE_LO_IDX,         // Second entry
    input wire csrc_clear_type CLR_CMD            // Clear pulse
);
    logic       sck_q, sck_d;
    logic [5:0] falls_q, falls_d;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // Falls while driving: TA second bit plus 32 data bits
    always_comb begin
        sck_d   = SERIAL_PORT_CLOCK;
        falls_d = DATA_OE ? falls_q + {5'h00, sck_q & ~SERIAL_PORT_CLOCK} : 6'h00;
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sck_q   <= 1'h0;
            falls_q <= 6'h00;
        end else begin
            sck_q   <= sck_d;
            falls_q <= falls_d;
        end
    end
    sequence s_sck_high;
        SERIAL_PORT_CLOCK [*4];
    endsequence
    a_data_span: assert property ($fell(DATA_OE) |-> falls_q == 6'h21 && !DATA_O)
        else $error("drive span is not 32 data bits");
    a_data_steady: assert property (s_sck_high ##0 DATA_OE |-> $stable(DATA_O))
        else $error("data moved while link clock high");
    a_oe_start: assert property ($rose(DATA_OE) |-> !SERIAL_PORT_CLOCK && !DATA_O)
        else $error("drive began off the falling half");
    a_idle_quiet: assert property (!DATA_OE |-> !DATA_O)
        else $error("data set while released");
    a_clr_pulse: assert property (CLR_CMD.valid |=> !CLR_CMD.valid)
        else $error("clear pulse longer than one cycle");
    a_clr_timing: assert property (CLR_CMD.valid |-> SERIAL_PORT_CLOCK && !DATA_OE)
        else $error("clear pulse outside last bit");
    a_clr_fields: assert property (!CLR_CMD.valid |-> !CLR_CMD.scope && CLR_CMD.index == 7'h00)
        else $error("clear fields set without pulse");
    a_ee_pair: assert property ($changed(EE_LO_IDX) || $changed(EE_HI_IDX)
        |-> EE_HI_IDX == {EE_LO_IDX[6:1], 1'h1} && !EE_LO_IDX[0])
        else $error("entry pair not odd then even");
endmodule : csrc_props
`default_nettype wire

// [verif/csrc_ctrl.sv]
// Purpose: Management controller model sending frames on the link
// Assumes: Pull-up on the data wire, resolved by the bench
// Notes:   Link clock rests low between frames, one idle toggle after each
`timescale 1ns/100ps
`default_nettype none
module csrc_ctrl (
    output var logic sck, // Link clock
    output var logic d,   // Controller data
    output var logic oe,  // Controller drives
    input wire logic dio  // Wire level
);
    initial begin
        sck = 1'h0;
        d   = 1'h0;
        oe  = 1'h0;
    end
    // Data moves after falling edge, read bits taken at rising edge
    task automatic xfer(input int pre, input logic [13:0] hdr, input int nb, input int nrd,
        output logic [31:0] q);
        int n;
        n = pre + nb;
        q = 32'h00000000;
        #1.3;
        for (int i = 0; i < n + nrd + 1; i++) begin
            oe = i < n;
            d = i < pre ? 1'h1 : (i < n ? hdr[n - 1 - i] : 1'h0);
            #62.5 sck = 1'h1;
            if (i >= n + 2 && i < n + nrd) q = {q[30:0], dio};
            #62.5 sck = 1'h0;
        end
        oe = 1'h0;
    endtask : xfer
endmodule : csrc_ctrl
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench of the serial read and clear port
// Assumes: Counter store and wrap sources modelled here
// Notes:   Flag expectations follow wrap pulses and clears sent
`timescale 1ns/100ps
`default_nettype none
module tb;
    import csrc_pkg::*;
    logic           MCLK = 1'h0;
    logic           RST  = 1'h1;
    logic [1:0]     strap;
    logic [6:0]     cnt_addr, ee_hi, ee_lo;
    logic [31:0]    cnt_data, got, r;
    logic [63:0]    fl;
    csrc_wrap_type  wrap = 20'h00000;
    csrc_clear_type clr;
    csrc_clear_type clr_seen = '0;
    int             clr_cnt = 0;
    logic           sck, cd, coe, dio, d_o, d_oe;
    logic [31:0]    cmem [128];
    logic [15:0]    emem [128];
    int             seed = 95;
    int             error_cnt = 0;
    int             num_checks = 0;
    always #2.5 MCLK = ~MCLK;
    assign dio = d_oe ? d_o : (coe ? cd : 1'h1);
    assign cnt_data = cmem[cnt_addr];
    csrc_port uut (.MCLK(MCLK), .RST(RST), .SERIAL_PORT_CLOCK(sck), .DATA_I(dio), .DATA_O(d_o),
        .DATA_OE(d_oe), .STRAPPED_PHYSICAL_ADDRESS(strap), .CNT_ADDR(cnt_addr), .CNT_DATA(cnt_data),
        .EE_HI_IDX(ee_hi), .EE_LO_IDX(ee_lo), .EE_HI_WORD(emem[ee_hi]), .EE_LO_WORD(emem[ee_lo]),
        .WRAP(wrap), .CLR_CMD(clr));
    csrc_ctrl ctl (.sck(sck), .d(cd), .oe(coe), .dio(dio));
    // Last clear command handed to the counter store
    always @(posedge MCLK) begin
        if (clr.valid) begin
            clr_seen <= clr;
            clr_cnt  <= clr_cnt + 1;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Kind 0..3 is tx pkt, tx byte, col, err; col and err in upper word
    function automatic logic [63:0] pos(input int k, input int p);
        return 64'h1 << ((p == 4 ? 7 : 2 * p) + k % 2 * 9 + k / 2 * 32);
    endfunction : pos
    function automatic logic [31:0] exp_rd(input logic t, input logic [6:0] a);
        if (!t) return {emem[a | 7'h01], emem[a & 7'h7E]};
        return a == 7'h3B ? fl[31:0] : (a == 7'h3C ? fl[63:32] : cmem[a]);
    endfunction : exp_rd
    task automatic rd(input logic t, input logic [6:0] a);
        ctl.xfer(32, {2'h0, 2'h1, 2'h2, t, a}, 12, 34, got);
        chk("read word", exp_rd(t, a), got);
    endtask : rd
    task automatic flags(input string s);
        rd(1'h1, 7'h3B);
        rd(1'h1, 7'h3C);
        $display("test %s finished", s);
    endtask : flags
    task automatic pulse(input int k, input int p);
        @(negedge MCLK);
        wrap = 20'h00001 << ((3 - k) * 5 + p);
        fl |= pos(k, p);
        @(negedge MCLK);
        wrap = 20'h00000;
    endtask : pulse
    task automatic clear(input logic [1:0] dev, input logic s, input logic [6:0] x);
        int n0;
        n0 = clr_cnt;
        ctl.xfer(32, {2'h1, 2'h1, dev, s, x}, 14, 0, got);
        chk("clear pulses", {31'h0, dev == strap}, clr_cnt - n0);
        if (dev == strap) chk("clear command", {23'h0, 1'h1, s, x}, clr_seen);
        for (int k = 0; k < 20; k++) begin
            if (dev == strap && (s ? k % 5 == x : 32 + k / 5 * 8 + k % 5 == x)) fl &= ~pos(k / 5, k % 5);
        end
    endtask : clear
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        r = $random(seed);
        strap = r[1:0];
        fl = 64'h0;
        for (int i = 0; i < 128; i++) begin
            cmem[i] = $random(seed);
            r = $random(seed);
            emem[i] = r[15:0];
        end
        repeat (10) @(posedge MCLK);
        @(negedge MCLK) RST = 1'h0;
        repeat (12) @(negedge MCLK);
        flags("reset values");
        rd(1'h0, 7'h00);
        rd(1'h0, 7'h03);
        rd(1'h0, 7'h7F);
        rd(1'h1, 7'h10);
        repeat (6) begin
            r = $random(seed);
            rd(r[7], r[6:0]);
        end
        $display("test reads finished");
        // Idle toggle before it adds one pull-up one, so 31 in all
        ctl.xfer(30, {2'h0, 2'h1, 2'h2, 1'h1, 7'h05}, 12, 34, got);
        chk("short preamble", 32'hFFFFFFFF, got);
        ctl.xfer(32, {2'h0, 2'h1, 2'h3, 1'h1, 7'h05}, 12, 34, got);
        chk("bad opcode", 32'hFFFFFFFF, got);
        $display("test refusals finished");
        for (int k = 0; k < 4; k++) pulse(k, 4);
        repeat (12) begin
            r = $random(seed);
            pulse(r[1:0], r[4:2] % 5);
        end
        pulse(3, 2);
        flags("wraps");
        clear(~strap, 1'h1, 7'h04);
        flags("foreign clear");
        clear(strap, 1'h1, 7'h04);
        flags("port clear");
        clear(strap, 1'h0, 7'h3A);
        flags("counter clear");
        @(negedge MCLK) RST = 1'h1;
        fl = 64'h0;
        @(negedge MCLK) RST = 1'h0;
        repeat (12) @(negedge MCLK);
        flags("second reset");
        print_verdict;
    end
endmodule : tb
bind csrc_port csrc_props chk (.MCLK(MCLK), .RST(RST), .SERIAL_PORT_CLOCK(SERIAL_PORT_CLOCK),
    .DATA_O(DATA_O), .DATA_OE(DATA_OE), .EE_HI_IDX(EE_HI_IDX), .EE_LO_IDX(EE_LO_IDX), .CLR_CMD(CLR_CMD));
`default_nettype wire
